// >>> cgc_clock_control.v
// Purpose: clock generator control: pll mode, output gates, power state,
//          and enables for the fixed-rate on-chip clocks
// Assumes: register port is synchronous to core_clk_in; analog pll,
//          oscillators and dividers sit outside and take these controls
// Notes:   a clock output gate changes only while its clock is low
//
// Behaviour
// - mode codes 000/100 off, others pick reference
// - two independent output enable bits, high enables
// - pending processor interrupt sets power-on bit
// - writing one to power-on bit clears it
// - master, slow and touch clock removal delayed after power-on clear
// - master clock runs whenever generator powered
// - spread applied to converter clock, 1 or 2 percent
// - processor and access controller on master clock
// - 1k, 8k and 32k clocks to slow consumers
// - 24M, 4k to converters, 2M to touch
// - audio on 48M or external clock; class d
`timescale 1ns/10ps
`include "cgc_consts.vh"

module cgc_clock_control #(
   parameter PD_DELAY = `CGC_PD_DELAY_CYC
) (
   // clock and reset
   input  wire       core_clk_in,
   input  wire       rst_in,
   // register port
   input  wire [15:0] reg_addr_in,
   input  wire       reg_wr_in,
   input  wire [7:0] reg_wdata_in,
   output reg  [7:0] reg_rdata_out,
   // power state
   input  wire       cpu_irq_pending_in,
   output reg        clock_generator_power_on_out,
   output reg        generator_clocks_run_out,
   // pll control
   output reg        pll_power_out,
   output reg  [2:0] pll_reference_out,
   output reg        spread_spectrum_enable_out,
   output reg  [1:0] spread_offset_pct_out,
   // external clock gating
   input  wire       pll_12m_clk_in,
   input  wire       pll_48m_clk_in,
   output wire       system_clock_output_out,
   output wire       usb_clock_output_out,
   // on-chip clock enables
   input  wire       audio_ext_mclk_sel_in,
   output reg        master_logic_clock_en_out,
   output reg        slow_clocks_en_out,
   output reg        dcdc_clocks_en_out,
   output reg        touch_clock_en_out,
   output reg        audio_48m_en_out,
   output reg        audio_mclk_sel_out,
   output reg        classd_clock_en_out
);

   // ********************************
   // configuration register
   // ********************************
   reg  [7:0] cfg_q;
   reg  [7:0] cfg_d;
   reg        pwr_q;
   reg        pwr_d;
   reg  [7:0] pd_cnt_q;
   reg  [7:0] pd_cnt_d;
   reg        sys_gate_q;
   reg        usb_gate_q;
   wire       cfg_sel;
   wire       pst_sel;
   wire       pll_on;
   wire [2:0] mode;

   assign cfg_sel = (reg_addr_in == `CGC_PLL_CFG_ADDR);
   assign pst_sel = (reg_addr_in == `CGC_PSTATE_ADDR);
   assign mode    = cfg_q[`CGC_MODE_MSB:`CGC_MODE_LSB];

   always @* begin
      cfg_d = cfg_q;
      if (reg_wr_in && cfg_sel) begin
         cfg_d = reg_wdata_in;
      end
   end

   // ********************************
   // power state handshake
   // ********************************
   // irq set wins over a software clear in the same cycle
   always @* begin
      pwr_d = pwr_q;
      if (reg_wr_in && pst_sel && reg_wdata_in[`CGC_CLOCK_GENERATOR_POWER_ON_BIT]) begin
         pwr_d = 1'b0;
      end
      if (cpu_irq_pending_in) begin
         pwr_d = 1'b1;
      end
   end

   // hold clocks a few cycles so the clearing access can finish
   always @* begin
      pd_cnt_d = pd_cnt_q;
      if (pwr_q) begin
         pd_cnt_d = PD_DELAY[7:0];
      end else if (pd_cnt_q != 8'h00) begin
         pd_cnt_d = pd_cnt_q - 8'h01;
      end
   end

   always @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         cfg_q    <= `CGC_PLL_CFG_RESET;
         pwr_q    <= 1'b1;
         pd_cnt_q <= 8'h00;
      end else begin
         cfg_q    <= cfg_d;
         pwr_q    <= pwr_d;
         pd_cnt_q <= pd_cnt_d;
      end
   end

   // ********************************
   // pll mode decode
   // ********************************
   assign pll_on = (mode != `CGC_MODE_OFF_A) && (mode != `CGC_MODE_OFF_B);

   always @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         reg_rdata_out                <= 8'h00;
         clock_generator_power_on_out <= 1'b1;
         generator_clocks_run_out     <= 1'b1;
         pll_power_out                <= 1'b0;
         pll_reference_out            <= `CGC_REF_NONE;
         spread_spectrum_enable_out   <= 1'b0;
         spread_offset_pct_out        <= `CGC_SPREAD_1PCT;
         master_logic_clock_en_out    <= 1'b1;
         slow_clocks_en_out           <= 1'b1;
         dcdc_clocks_en_out           <= 1'b0;
         touch_clock_en_out           <= 1'b1;
         audio_48m_en_out             <= 1'b0;
         audio_mclk_sel_out           <= 1'b0;
         classd_clock_en_out          <= 1'b0;
      end else begin
         // unmapped addresses and unused power-state bits read zero
         reg_rdata_out <= 8'h00;
         if (cfg_sel) begin
            reg_rdata_out <= cfg_q;
         end else if (pst_sel) begin
            reg_rdata_out[`CGC_CLOCK_GENERATOR_POWER_ON_BIT] <= pwr_q;
         end
         clock_generator_power_on_out <= pwr_q;
         generator_clocks_run_out <= pwr_q || (pd_cnt_q != 8'h00);
         // master clock follows generator power only, whether the pll is on or off
         master_logic_clock_en_out <= pwr_q || (pd_cnt_q != 8'h00);
         slow_clocks_en_out <= pwr_q || (pd_cnt_q != 8'h00);
         touch_clock_en_out <= pwr_q || (pd_cnt_q != 8'h00);
         pll_power_out <= pll_on && pwr_q;
         case (mode)
            `CGC_MODE_26M_A: pll_reference_out <= `CGC_REF_26M;
            `CGC_MODE_26M_B: pll_reference_out <= `CGC_REF_26M;
            `CGC_MODE_32K:   pll_reference_out <= `CGC_REF_32K;
            `CGC_MODE_12M:   pll_reference_out <= `CGC_REF_12M;
            `CGC_MODE_13M:   pll_reference_out <= `CGC_REF_13M;
            `CGC_MODE_19M2:  pll_reference_out <= `CGC_REF_19M2;
            default:         pll_reference_out <= `CGC_REF_NONE;
         endcase
         dcdc_clocks_en_out <= pll_on && pwr_q;
         spread_spectrum_enable_out <= cfg_q[`CGC_SPREAD_EN_BIT] &&
                                       pll_on;
         spread_offset_pct_out <= cfg_q[`CGC_SPREAD_OFS_BIT] ?
                                  `CGC_SPREAD_2PCT :
                                  `CGC_SPREAD_1PCT;
         // audio takes pll 48m unless the external master clock is picked
         audio_mclk_sel_out <= audio_ext_mclk_sel_in;
         audio_48m_en_out <= pll_on && pwr_q &&
                             !audio_ext_mclk_sel_in;
         classd_clock_en_out <= (pll_on && pwr_q) ||
                                audio_ext_mclk_sel_in;
      end
   end

   // ********************************
   // glitch-free output gates
   // ********************************
   // enables settle in a core flop first so each gate domain sees one
   // clean bit, then two falling-edge stages absorb metastability;
   // cost is up to two source periods before a gate moves
   reg        sys_en_q;
   reg        usb_en_q;
   reg        sys_meta_q;
   reg        usb_meta_q;

   always @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         sys_en_q <= 1'b0;
         usb_en_q <= 1'b0;
      end else begin
         sys_en_q <= cfg_q[`CGC_SYS_OE_BIT] && pll_on && pwr_q;
         usb_en_q <= cfg_q[`CGC_USB_OE_BIT] && pll_on && pwr_q;
      end
   end

   // gate flops move on the falling source edge, so the and-gate never
   // opens or closes mid high phase
   always @(negedge pll_12m_clk_in or posedge rst_in) begin
      if (rst_in) begin
         sys_meta_q <= 1'b0;
         sys_gate_q <= 1'b0;
      end else begin
         sys_meta_q <= sys_en_q;
         sys_gate_q <= sys_meta_q;
      end
   end

   always @(negedge pll_48m_clk_in or posedge rst_in) begin
      if (rst_in) begin
         usb_meta_q <= 1'b0;
         usb_gate_q <= 1'b0;
      end else begin
         usb_meta_q <= usb_en_q;
         usb_gate_q <= usb_meta_q;
      end
   end

   assign system_clock_output_out = pll_12m_clk_in & sys_gate_q;
   assign usb_clock_output_out    = pll_48m_clk_in & usb_gate_q;

endmodule

// >>> cgc_consts.vh
// Purpose: constants for the clock generator control block
// Assumes: 125 MHz core clock
// Notes:   register offsets, field positions, reset values and divides
`ifndef CGC_CONSTS_VH
`define CGC_CONSTS_VH

// ********************************
// register map
// ********************************
`define CGC_PLL_CFG_ADDR   16'ha034
`define CGC_PSTATE_ADDR    16'ha031
`define CGC_PLL_CFG_RESET  8'hc0
`define CGC_CLOCK_GENERATOR_POWER_ON_BIT  4

// ********************************
// pll configuration fields
// ********************************
`define CGC_MODE_LSB       0
`define CGC_MODE_MSB       2
`define CGC_SPREAD_OFS_BIT 4
`define CGC_SPREAD_EN_BIT  5
`define CGC_SYS_OE_BIT     6
`define CGC_USB_OE_BIT     7

// ********************************
// mode codes and references
// ********************************
`define CGC_MODE_OFF_A     3'h0
`define CGC_MODE_26M_A     3'h1
`define CGC_MODE_32K       3'h2
`define CGC_MODE_26M_B     3'h3
`define CGC_MODE_OFF_B     3'h4
`define CGC_MODE_12M       3'h5
`define CGC_MODE_13M       3'h6
`define CGC_MODE_19M2      3'h7
`define CGC_REF_NONE       3'h0
`define CGC_REF_26M        3'h1
`define CGC_REF_32K        3'h2
`define CGC_REF_12M        3'h3
`define CGC_REF_13M        3'h4
`define CGC_REF_19M2       3'h5

// ********************************
// timing
// ********************************
`define CGC_PD_DELAY_NS    64
`define CGC_CLK_PERIOD_NS  8
`define CGC_PD_DELAY_CYC   (`CGC_PD_DELAY_NS / `CGC_CLK_PERIOD_NS)
`define CGC_SPREAD_1PCT    2'h1
`define CGC_SPREAD_2PCT    2'h2

`endif

// >>> cgc_clock_control_chk.sv
// Purpose: port assertions for the clock generator control
// Assumes: bound to cgc_clock_control by the bench
// Notes:   all waits are counted in core clock cycles
`timescale 1ns/10ps
module cgc_clock_control_chk #(
   parameter PD_DELAY = 8
) (
   // clock, reset and register port
   input wire logic        core_clk_in,
   input wire logic        rst_in,
   input wire logic [15:0] reg_addr_in,
   input wire logic        reg_wr_in,
   input wire logic [7:0]  reg_wdata_in,
   input wire logic [7:0]  reg_rdata_out,
   // power state and pll
   input wire logic        cpu_irq_pending_in,
   input wire logic        clock_generator_power_on_out,
   input wire logic        generator_clocks_run_out,
   input wire logic        pll_power_out,
   input wire logic [2:0]  pll_reference_out,
   input wire logic [1:0]  spread_offset_pct_out,
   input wire logic        system_clock_output_out,
   input wire logic        usb_clock_output_out
);
   // margin over the countdown covers the two register stages
   localparam int RUN_MAX = PD_DELAY + 4;
   default clocking @(posedge core_clk_in);
   endclocking
   default disable iff (rst_in);
   // ****************
   // assertions
   // ****************
   sequence s_cfg_wr;
      reg_wr_in && reg_addr_in == 16'ha034;
   endsequence
   a_mode_off: assert property ((s_cfg_wr ##0 reg_wdata_in[1:0] == 2'h0)
      |-> ##2 !pll_power_out) else $error("pll on for an off code");
   a_mode_ref: assert property ((s_cfg_wr ##0 reg_wdata_in[2:0] == 3'h5)
      |-> ##2 pll_reference_out == 3'h3) else $error("wrong reference");
   a_cfg_read: assert property ((s_cfg_wr ##1 reg_addr_in == 16'ha034)
      |-> ##1 reg_rdata_out == $past(reg_wdata_in, 2))
      else $error("config readback wrong");
   a_irq_set: assert property (cpu_irq_pending_in
      |-> ##2 clock_generator_power_on_out) else $error("irq kept power off");
   a_pwr_clear: assert property (reg_wr_in && reg_addr_in == 16'ha031
      && reg_wdata_in[4] && !cpu_irq_pending_in
      |-> ##2 !clock_generator_power_on_out) else $error("power bit kept");
   a_run_hold: assert property ($fell(clock_generator_power_on_out)
      |-> generator_clocks_run_out[*4]) else $error("clocks cut at once");
   a_run_stop: assert property ($fell(clock_generator_power_on_out)
      |-> ##[1:RUN_MAX] !generator_clocks_run_out) else $error("clocks kept");
   a_ofs_two: assert property ((s_cfg_wr ##0 reg_wdata_in[4])
      |-> ##2 spread_offset_pct_out == 2'h2) else $error("offset not 2");
   a_gate_low: assert property (!pll_power_out[*8]
      |-> !system_clock_output_out && !usb_clock_output_out)
      else $error("gated clock high with pll off");
   a_unmapped: assert property (reg_addr_in != 16'ha034
      && reg_addr_in != 16'ha031 |=> reg_rdata_out == 8'h00)
      else $error("unmapped read not zero");
endmodule

// >>> cgc_pll_model.sv
// Purpose: stand-in for the analog pll feeding the output gates
// Assumes: pll runs only while the control powers it
// Notes:   a stopped pll parks its clocks low, so gates see no edges
`timescale 1ns/10ps
module cgc_pll_model (
   // control
   input  wire logic pll_power_in,
   // generated clocks
   output logic      clk_12m_out,
   output logic      clk_48m_out
);
   // ****************
   // clocks
   // ****************
   initial begin
      clk_12m_out = 1'b0;
      forever #41.67 clk_12m_out = pll_power_in & ~clk_12m_out;
   end
   initial begin
      clk_48m_out = 1'b0;
      forever #10.42 clk_48m_out = pll_power_in & ~clk_48m_out;
   end
endmodule

// >>> tb_cgc_clock_control.sv
// Purpose: self-checking bench for the clock generator control
// Assumes: PD_DELAY left at its default
// Notes:   inputs move 1 ns after the rising edge
`timescale 1ns/10ps
module tb_cgc_clock_control;
   logic        clk, rst, wr, irq;
   logic [15:0] addr;
   logic [7:0]  wd;
   wire  [7:0]  rd;
   wire  [2:0]  rf;
   wire  [1:0]  ofs;
   wire         pon, run, pp, sse, so, uo, men, c12, c48;
   wire         slo, dce, tce, a48, ams, cde;
   logic        ems;
   int          errors, n_tests;
   cgc_clock_control i_dut (.core_clk_in(clk), .rst_in(rst),
      .reg_addr_in(addr), .reg_wr_in(wr), .reg_wdata_in(wd),
      .reg_rdata_out(rd), .cpu_irq_pending_in(irq),
      .clock_generator_power_on_out(pon), .generator_clocks_run_out(run),
      .pll_power_out(pp), .pll_reference_out(rf),
      .spread_spectrum_enable_out(sse), .spread_offset_pct_out(ofs),
      .pll_12m_clk_in(c12), .pll_48m_clk_in(c48),
      .system_clock_output_out(so), .usb_clock_output_out(uo),
      .audio_ext_mclk_sel_in(ems), .master_logic_clock_en_out(men),
      .slow_clocks_en_out(slo), .dcdc_clocks_en_out(dce),
      .touch_clock_en_out(tce), .audio_48m_en_out(a48),
      .audio_mclk_sel_out(ams), .classd_clock_en_out(cde));
   cgc_pll_model i_pll (.pll_power_in(pp), .clk_12m_out(c12),
      .clk_48m_out(c48));
   // ****************
   // tasks
   // ****************
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic cyc(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(string nm, logic [7:0] got, logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
         errors++;
      end
   endtask
   // an idle cycle follows each write so the strobe never re-rises at once
   task automatic wr_reg(logic [15:0] a, logic [7:0] d);
      addr = a;
      wd = d;
      wr = 1'b1;
      cyc(1);
      wr = 1'b0;
      cyc(1);
   endtask
   task automatic rd_reg(logic [15:0] a, logic [7:0] e);
      addr = a;
      cyc(1);
      chk("rdata", rd, e);
   endtask
   task automatic t_modes();
      logic [2:0] ref_tab [8] = '{3'h0, 3'h1, 3'h2, 3'h1, 3'h0, 3'h3, 3'h4,
                                  3'h5};
      for (int m = 0; m < 8; m++) begin
         wr_reg(16'ha034, {2'h3, m[1:0], 1'b0, m[2:0]});
         chk("pll_power", pp, m[1:0] != 2'h0);
         chk("reference", rf, ref_tab[m]);
         chk("spread_en", sse, m[1]);
         chk("offset", ofs, m[0] ? 2'h2 : 2'h1);
         rd_reg(16'ha034, {2'h3, m[1:0], 1'b0, m[2:0]});
      end
   endtask
   task automatic t_gates();
      logic hs, hu;
      for (int g = 0; g < 4; g++) begin
         wr_reg(16'ha034, {g[1:0], 6'h05});
         // gate enables pass a core flop and two slow-clock stages
         cyc(30);
         hs = 1'b0;
         hu = 1'b0;
         repeat (30) begin
            cyc(1);
            hs |= so;
            hu |= uo;
         end
         chk("sys_clock", hs, g[0]);
         chk("usb_clock", hu, g[1]);
      end
   endtask
   task automatic t_power();
      irq = 1'b1;
      wr_reg(16'ha031, 8'h10);
      chk("power_on", pon, 1'b1);
      irq = 1'b0;
      wr_reg(16'ha031, 8'h10);
      chk("power_on", pon, 1'b0);
      chk("clocks_run", run, 1'b1);
      for (int i = 0; i < 20 && run !== 1'b0; i++)
         cyc(1);
      chk("clocks_run", run, 1'b0);
      chk("master_en", men, 1'b0);
      chk("slow_en", slo, 1'b0);
      chk("touch_en", tce, 1'b0);
      chk("dcdc_en", dce, 1'b0);
      if (run !== 1'b0)
         finish_test();
      irq = 1'b1;
      cyc(2);
      chk("power_on", pon, 1'b1);
      irq = 1'b0;
      cyc(3);
      chk("master_en", men, 1'b1);
      chk("dcdc_en", dce, 1'b1);
      rd_reg(16'ha031, 8'h10);
   endtask
   task automatic t_audio();
      for (int e = 0; e < 2; e++) begin
         ems = e[0];
         wr_reg(16'ha034, 8'hc0);
         chk("dcdc_en", dce, 1'b0);
         chk("audio_48m", a48, 1'b0);
         chk("classd_en", cde, e[0]);
         chk("mclk_sel", ams, e[0]);
         wr_reg(16'ha034, 8'hc6);
         chk("dcdc_en", dce, 1'b1);
         chk("audio_48m", a48, !e[0]);
         chk("classd_en", cde, 1'b1);
         chk("slow_en", slo, 1'b1);
         chk("touch_en", tce, 1'b1);
      end
      ems = 1'b0;
   endtask
   // a reset mid-run must also restore the configuration defaults
   task automatic t_reset(int n);
      rst = 1'b1;
      cyc(n);
      rst = 1'b0;
      cyc(1);
      chk("pll_power", pp, 1'b0);
      chk("master_en", men, 1'b1);
      rd_reg(16'ha034, 8'hc0);
   endtask
   task automatic finish_test();
      if (errors == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      {rst, wr, irq, addr, wd} = {3'h4, 16'h0000, 8'h00};
      ems = 1'b0;
      errors = 0;
      n_tests = 0;
      t_reset(4);
      rd_reg(16'ha000, 8'h00);
      t_modes();
      t_gates();
      t_audio();
      t_power();
      t_reset(2);
      finish_test();
   end
endmodule
bind cgc_clock_control cgc_clock_control_chk #(.PD_DELAY(PD_DELAY)) i_chk (
   .core_clk_in(core_clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
   .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in),
   .reg_rdata_out(reg_rdata_out), .cpu_irq_pending_in(cpu_irq_pending_in),
   .clock_generator_power_on_out(clock_generator_power_on_out),
   .generator_clocks_run_out(generator_clocks_run_out),
   .pll_power_out(pll_power_out), .pll_reference_out(pll_reference_out),
   .spread_offset_pct_out(spread_offset_pct_out),
   .system_clock_output_out(system_clock_output_out),
   .usb_clock_output_out(usb_clock_output_out));
